/* File: half_bridge_serial_control.v */
`timescale 1ns/1ns
`include "hbridge_defines.vh"

module half_bridge_serial_control
(
    clk_sys,
    rst,
    select_n,
    serial_clk,
    serial_in,
    inhibit_pin_n,
    temp_prewarn,
    temp_shutdown,
    supply_under,
    short_sense,
    open_load_sense,
    serial_out,
    serial_out_oe,
    stage_drive,
    open_load_detect_n,
    short_delay_select,
    open_load_current_en
);
    input  wire        clk_sys;
    input  wire        rst;
    input  wire        select_n;
    input  wire        serial_clk;
    input  wire        serial_in;
    input  wire        inhibit_pin_n;
    input  wire        temp_prewarn;
    input  wire        temp_shutdown;
    input  wire        supply_under;
    input  wire [11:0] short_sense;
    input  wire [11:0] open_load_sense;
    output reg         serial_out;
    output reg         serial_out_oe;
    output reg  [11:0] stage_drive;
    output reg         open_load_detect_n;
    output reg         short_delay_select;
    output reg  [11:0] open_load_current_en;

    wire sel_s;
    wire sclk_s;
    wire din_s;
    wire inh_s;
    wire tpw_s;
    wire tsd_s;
    wire uv_s;
    wire [11:0] short_s;
    wire [11:0] open_s;
    wire [11:0] short_fire;
    wire        sel_sync_n;

    // select is synchronised inverted so its idle-high level holds through reset;
    // a zero out of reset would fake a select fall and open a frame
    sync2 u_sel
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .async_in(~select_n),
        .sync_out(sel_sync_n)
    );
    assign sel_s = ~sel_sync_n;

    // serial clock idles low, so a zero out of reset gives no false edge
    sync2 u_sclk
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .async_in(serial_clk),
        .sync_out(sclk_s)
    );

    // data shares the clock's latency, so it lines up with the found edge
    sync2 u_din
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .async_in(serial_in),
        .sync_out(din_s)
    );

    // reads as inhibit for two cycles after reset; stages are off then anyway
    sync2 u_inh
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .async_in(inhibit_pin_n),
        .sync_out(inh_s)
    );

    sync2 u_tpw
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .async_in(temp_prewarn),
        .sync_out(tpw_s)
    );

    sync2 u_tsd
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .async_in(temp_shutdown),
        .sync_out(tsd_s)
    );

    sync2 u_uv
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .async_in(supply_under),
        .sync_out(uv_s)
    );

    reg  [`WORD_BITS-1:0] ctrl_reg;
    reg  [`WORD_BITS-1:0] rx_shift_reg;
    reg  [`WORD_BITS-1:0] tx_shift_reg;
    reg  [4:0]            bit_count_reg;
    reg                   sel_d_reg;
    reg                   sclk_d_reg;
    reg                   in_frame_reg;
    reg                   supply_fail_reg;
    reg                   shutdown_reg;
    reg  [11:0]           short_off_reg;
    reg  [`WORD_BITS-1:0] status_word;

    wire sel_fall   = sel_d_reg & ~sel_s;
    wire sel_rise   = ~sel_d_reg & sel_s;
    wire sclk_fall  = sclk_d_reg & ~sclk_s;
    wire sclk_rise  = ~sclk_d_reg & sclk_s;
    wire run_enable = ctrl_reg[`CTRL_SW_RUN] & inh_s;
    wire full_word  = (bit_count_reg == 5'h10);
    wire clear_req  = sel_rise & in_frame_reg & full_word & rx_shift_reg[`CTRL_STATUS_CLEAR];
    // stages drop while undervoltage persists and come back as soon as it goes
    wire supply_fail_now = uv_s;
    wire stages_ok  = run_enable & ~supply_fail_now & ~shutdown_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 12; gi = gi + 1)
        begin : g_stage
            sync2 u_sc
            (
                .clk_sys (clk_sys),
                .rst     (rst),
                .async_in(short_sense[gi]),
                .sync_out(short_s[gi])
            );
            sync2 u_ol
            (
                .clk_sys (clk_sys),
                .rst     (rst),
                .async_in(open_load_sense[gi]),
                .sync_out(open_s[gi])
            );
            // prewarning bypasses the delay and shuts the shorted stage at once
            short_timer u_tmr (
                .clk_sys     (clk_sys),
                .rst         (rst),
                .short_active(short_s[gi] & stage_drive[gi]),
                .long_select (ctrl_reg[`CTRL_SHORT_DELAY]),
                .bypass      (tpw_s),
                .expired     (short_fire[gi])
            );
        end
    endgenerate

    integer k;
    integer j;
    always @*
    begin
        status_word = 16'h0000;
        status_word[`STAT_TEMP_PREWARN] = tpw_s;
        for (k = 0; k < 12; k = k + 1)
        begin
            if (!ctrl_reg[`CTRL_OPEN_LOAD_N] && !ctrl_reg[k + 1])
                status_word[k + 1] = open_s[k];
            else
                status_word[k + 1] = stage_drive[k];
        end
        status_word[`STAT_SHORT]        = |short_off_reg;
        status_word[`STAT_INHIBIT]      = ~run_enable;
        status_word[`STAT_SUPPLY_FAIL]  = supply_fail_reg;
        if (shutdown_reg)
            status_word = `STAT_ALL_ONES;
    end

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_reg             <= `CTRL_RESET;
            rx_shift_reg         <= 16'h0000;
            tx_shift_reg         <= 16'h0000;
            bit_count_reg        <= 5'h00;
            sel_d_reg            <= 1'b1;
            sclk_d_reg           <= 1'b0;
            in_frame_reg         <= 1'b0;
            supply_fail_reg      <= 1'b0;
            shutdown_reg         <= 1'b0;
            short_off_reg        <= 12'h000;
            serial_out           <= 1'b0;
            serial_out_oe        <= 1'b0;
            stage_drive          <= 12'h000;
            open_load_detect_n   <= 1'b1;
            short_delay_select   <= 1'b1;
            open_load_current_en <= 12'h000;
        end
        else
        begin
            sel_d_reg  <= sel_s;
            sclk_d_reg <= sclk_s;

            if (sel_fall)
            begin
                in_frame_reg  <= 1'b1;
                bit_count_reg <= 5'h00;
                tx_shift_reg  <= status_word;
                serial_out    <= status_word[0];
                serial_out_oe <= 1'b1;
            end
            else if (sel_rise)
            begin
                in_frame_reg  <= 1'b0;
                serial_out_oe <= 1'b0;
                // short frames abort and leave the control word as it was
                if (in_frame_reg && full_word)
                    ctrl_reg <= rx_shift_reg;
            end
            else if (in_frame_reg && !sel_s)
            begin
                if (sclk_fall)
                begin
                    rx_shift_reg <= {din_s, rx_shift_reg[15:1]};
                    if (!full_word)
                        bit_count_reg <= bit_count_reg + 5'h01;
                end
                if (sclk_rise && bit_count_reg != 5'h00)
                begin
                    tx_shift_reg <= {1'b0, tx_shift_reg[15:1]};
                    serial_out   <= tx_shift_reg[1];
                end
            end

            // set wins over clear on the sticky flags
            if (uv_s)
                supply_fail_reg <= 1'b1;
            else if (clear_req)
                supply_fail_reg <= 1'b0;

            if (tsd_s)
                shutdown_reg <= 1'b1;
            else if (clear_req)
                shutdown_reg <= 1'b0;

            // a stage shut off by a short stays off until the status clear
            for (j = 0; j < 12; j = j + 1)
            begin
                if (short_fire[j])
                    short_off_reg[j] <= 1'b1;
                else if (clear_req)
                    short_off_reg[j] <= 1'b0;
            end

            for (j = 0; j < 12; j = j + 1)
            begin
                stage_drive[j] <= stages_ok & ctrl_reg[j + 1] & ~short_off_reg[j]
                                  & ~short_fire[j];
                open_load_current_en[j] <= ~ctrl_reg[`CTRL_OPEN_LOAD_N]
                                           & ~ctrl_reg[j + 1];
            end
            open_load_detect_n <= ctrl_reg[`CTRL_OPEN_LOAD_N];
            short_delay_select <= ctrl_reg[`CTRL_SHORT_DELAY];
        end
    end
endmodule // half_bridge_serial_control

/* File: hbridge_chk.sv */
`timescale 1ns/1ns
module hbridge_chk
(
    input wire        clk_sys,
    input wire        rst,
    input wire        select_n,
    input wire        serial_clk,
    input wire        inhibit_pin_n,
    input wire        serial_out,
    input wire        serial_out_oe,
    input wire [11:0] stage_drive,
    input wire        open_load_detect_n,
    input wire        short_delay_select,
    input wire [11:0] open_load_current_en
);
    reg       sclk_q;
    reg       sel_q;
    reg [3:0] edge_cnt;
    reg [3:0] rise_cnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // cycles since a serial clock rise or select fall, and since a select rise
    always @(posedge clk_sys)
    begin
        sclk_q   <= serial_clk;
        sel_q    <= select_n;
        edge_cnt <= (serial_clk & ~sclk_q) | (sel_q & ~select_n) ? 4'h0 : edge_cnt + {3'h0, ~&edge_cnt};
        rise_cnt <= rst ? 4'hF : (select_n & ~sel_q) ? 4'h0 : rise_cnt + {3'h0, ~&rise_cnt};
    end
    oe_idle_a: assert property (select_n [*6] |-> !serial_out_oe)
        else $error("output driven while idle");
    oe_on_a: assert property ($fell(select_n) |-> ##[1:6] serial_out_oe)
        else $error("output not enabled");
    out_stable_a: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
        |-> edge_cnt < 4'h8) else $error("output moved between edges");
    ctrl_hold_a: assert property ($changed(short_delay_select) || $changed(open_load_detect_n)
        |-> rise_cnt < 4'hC) else $error("control changed mid frame");
    reset_val_a: assert property ($fell(rst) |-> stage_drive == 12'h000 && open_load_detect_n
        && short_delay_select && !serial_out_oe) else $error("bad reset state");
    inhibit_off_a: assert property (!inhibit_pin_n [*6] |-> stage_drive == 12'h000)
        else $error("stage on while inhibited");
    olc_idle_a: assert property (open_load_detect_n && $past(open_load_detect_n)
        |-> open_load_current_en == 12'h000) else $error("detect current while disabled");
    olc_stage_a: assert property (|stage_drive
        |-> (stage_drive & $past(stage_drive) & open_load_current_en) == 12'h000)
        else $error("detect current on a driven stage");
endmodule // hbridge_chk

bind half_bridge_serial_control hbridge_chk hbridge_chk_i
(
    .clk_sys(clk_sys), .rst(rst), .select_n(select_n), .serial_clk(serial_clk),
    .inhibit_pin_n(inhibit_pin_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .stage_drive(stage_drive), .open_load_detect_n(open_load_detect_n),
    .short_delay_select(short_delay_select), .open_load_current_en(open_load_current_en)
);

/* File: hbridge_defines.vh */
`ifndef HBRIDGE_DEFINES_VH
`define HBRIDGE_DEFINES_VH

`define WORD_BITS          16
`define CTRL_RESET         16'hE000
`define CTRL_STATUS_CLEAR  0
`define CTRL_STAGE_LO      1
`define CTRL_STAGE_HI      12
`define CTRL_OPEN_LOAD_N   13
`define CTRL_SHORT_DELAY   14
`define CTRL_SW_RUN        15
`define STAT_TEMP_PREWARN  0
`define STAT_SHORT         13
`define STAT_INHIBIT       14
`define STAT_SUPPLY_FAIL   15
`define STAT_ALL_ONES      16'hFFFF
`define CLK_PERIOD_NS      40
`define SHORT_DELAY_LONG_US  12000
`define SHORT_DELAY_SHORT_US 1500
`define SHORT_LONG_CYC   ((`SHORT_DELAY_LONG_US * 1000) / `CLK_PERIOD_NS)
`define SHORT_SHORT_CYC  ((`SHORT_DELAY_SHORT_US * 1000) / `CLK_PERIOD_NS)

`endif

/* File: hbridge_mcu.sv */
`timescale 1ns/1ns
module hbridge_mcu
(
    input  wire clk_sys,
    input  wire data_line,
    output reg  select_n,
    output reg  serial_clk,
    output reg  serial_in
);
    initial
    begin
        select_n   = 1'b1;
        serial_clk = 1'b0;
        serial_in  = 1'b0;
    end
    // frame of n bits; status bit i is read once the clock is low again
    task automatic xfer(input [15:0] tx, input integer n, output [15:0] rx);
        integer i;
        begin
            rx = 16'h0000;
            @(negedge clk_sys) select_n = 1'b0;
            repeat (8) @(negedge clk_sys);
            for (i = 0; i < n; i = i + 1)
            begin
                serial_in = tx[i];
                repeat (4) @(negedge clk_sys);
                serial_clk = 1'b1;
                repeat (4) @(negedge clk_sys);
                serial_clk = 1'b0;
                repeat (4) @(negedge clk_sys);
                rx[i] = data_line;
            end
            select_n  = 1'b1;
            serial_in = 1'b0;
            repeat (12) @(negedge clk_sys);
        end
    endtask
endmodule // hbridge_mcu

/* File: short_timer.v */
`timescale 1ns/1ns
`include "hbridge_defines.vh"
// counts while a short persists; fires once the selected delay has passed, or at once while bypass is set
module short_timer
#(
    parameter [31:0] LONG_CYC  = `SHORT_LONG_CYC,
    parameter [31:0] SHORT_CYC = `SHORT_SHORT_CYC
)
(
    clk_sys,
    rst,
    short_active,
    long_select,
    bypass,
    expired
);
    input  wire clk_sys;
    input  wire rst;
    input  wire short_active;
    input  wire long_select;
    input  wire bypass;
    output reg  expired;

    reg  [31:0] count_reg;
    wire [31:0] limit;

    assign limit = long_select ? LONG_CYC : SHORT_CYC;

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            count_reg <= 32'h00000000;
            expired   <= 1'b0;
        end
        else if (!short_active)
        begin
            count_reg <= 32'h00000000;
            expired   <= 1'b0;
        end
        else
        begin
            if (count_reg < limit)
                count_reg <= count_reg + 32'h00000001;
            expired <= bypass || (count_reg + 32'h00000001 >= limit);
        end
    end
endmodule // short_timer

/* File: sync2.v */
`timescale 1ns/1ns
module sync2
(
    clk_sys,
    rst,
    async_in,
    sync_out
);
    input  wire clk_sys;
    input  wire rst;
    input  wire async_in;
    output wire sync_out;

    reg first_reg;
    reg second_reg;

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            first_reg  <= 1'b0;
            second_reg <= 1'b0;
        end
        else
        begin
            first_reg  <= async_in;
            second_reg <= first_reg;
        end
    end

    assign sync_out = second_reg;
endmodule // sync2

/* File: tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared = n_compared + 1; if ((a) !== (b)) begin \
    fails = fails + 1; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    reg         clk_sys;
    reg         rst;
    reg         inhibit_pin_n;
    reg         temp_prewarn;
    reg         temp_shutdown;
    reg         supply_under;
    reg  [11:0] short_sense;
    reg  [11:0] ols;
    reg  [15:0] rx;
    wire        select_n;
    wire        serial_clk;
    wire        serial_in;
    wire        serial_out;
    wire        serial_out_oe;
    wire [11:0] stage_drive;
    wire        open_load_detect_n;
    wire        short_delay_select;
    wire [11:0] open_load_current_en;
    integer     fails;
    integer     n_compared;
    integer     cyc;
    integer     k;
    wire data_line = serial_out_oe ? serial_out : 1'bz;
    half_bridge_serial_control half_bridge_serial_control_i
    (
        .clk_sys(clk_sys), .rst(rst), .select_n(select_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .inhibit_pin_n(inhibit_pin_n), .temp_prewarn(temp_prewarn),
        .temp_shutdown(temp_shutdown), .supply_under(supply_under), .short_sense(short_sense),
        .open_load_sense(ols), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .stage_drive(stage_drive), .open_load_detect_n(open_load_detect_n),
        .short_delay_select(short_delay_select), .open_load_current_en(open_load_current_en)
    );
    hbridge_mcu mcu_i
    (
        .clk_sys(clk_sys), .data_line(data_line), .select_n(select_n),
        .serial_clk(serial_clk), .serial_in(serial_in)
    );
    task conclude;
        begin
            $display("compared %0d mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc = cyc + 1;
        if (cyc == 12000)
        begin
            fails = fails + 1;
            conclude;
        end
    end
    initial
    begin
        {rst, inhibit_pin_n, temp_prewarn, temp_shutdown, supply_under} = 5'h18;
        short_sense = 12'h000;
        ols = 12'hA5A;
        {fails, n_compared, cyc} = 0;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        `CHK({stage_drive, open_load_detect_n, short_delay_select, serial_out_oe}, 15'h0006)
        repeat (4) @(negedge clk_sys);
        for (k = 0; k < 4; k = k + 1)
        begin
            mcu_i.xfer({1'b1, k[1:0], 13'h0000}, 16, rx);
            `CHK({short_delay_select, open_load_detect_n}, k[1:0])
        end
        // one stage at a time; status shows the last stage on, open loads elsewhere
        for (k = 0; k < 12; k = k + 1)
        begin
            mcu_i.xfer(16'h8000 | (16'h0002 << k), 16, rx);
            `CHK(stage_drive, 12'h001 << k)
            `CHK(open_load_current_en, ~(12'h001 << k))
            if (k > 0)
                `CHK(rx, {3'h0, (12'h001 << (k - 1)) | (ols & ~(12'h001 << (k - 1))), 1'b0})
        end
        temp_prewarn = 1'b1;
        mcu_i.xfer(16'h7FFF, 1, rx);
        `CHK({rx[0], stage_drive}, 13'h1800)
        {temp_prewarn, inhibit_pin_n} = 2'h0;
        mcu_i.xfer(16'h8002, 16, rx);
        `CHK(stage_drive, 12'h000)
        inhibit_pin_n = 1'b1;
        mcu_i.xfer(16'h0002, 16, rx);
        `CHK({rx[14], stage_drive}, 13'h0000)
        mcu_i.xfer(16'h8002, 16, rx);
        `CHK({rx[14], stage_drive}, 13'h1001)
        {temp_prewarn, short_sense} = 13'h1001;
        repeat (10) @(negedge clk_sys);
        `CHK(stage_drive, 12'h000)
        {temp_prewarn, short_sense, supply_under} = 14'h0001;
        repeat (6) @(negedge clk_sys);
        supply_under = 1'b0;
        mcu_i.xfer(16'h8002, 16, rx);
        `CHK(rx[15:13], 3'h5)
        temp_shutdown = 1'b1;
        repeat (10) @(negedge clk_sys);
        mcu_i.xfer(16'h8002, 16, rx);
        `CHK(rx, 16'hFFFF)
        temp_shutdown = 1'b0;
        mcu_i.xfer(16'h8003, 16, rx);
        mcu_i.xfer(16'h8002, 16, rx);
        `CHK({rx, stage_drive}, 28'h14B6001)
        conclude;
    end
endmodule // tb_top
